// ### core/cis_pkg.sv
// Purpose: shared constants and types of the cpu interrupt source logic
// Assumes: 20-bit program addresses, 64 relocatable vector numbers
// Notes: vector numbers are shared by software interrupts and peripherals
package cis_pkg;
  localparam int PC_W = 20;
  localparam int NUM_W = 8;
  localparam int VEC_W = 6;
  localparam int AM_CH = 2;
  localparam int PER_N = 64;
  localparam logic [NUM_W-1:0] SWI_MAX = 8'h3F;
  localparam logic [NUM_W-1:0] SWI_LOW_MAX = 8'h1F;
  localparam logic OVF_RST = 1'h0;
  localparam logic SSEL_RST = 1'h0;
  localparam logic SSEL_IRQ = 1'h0;

  // class of the instruction in its execute cycle
  typedef enum logic [2:0] {
    OP_OTHER, OP_ARITH, OP_ILLEGAL, OP_OVF_TRAP, OP_BREAK, OP_SWI, OP_RET_SWI
  } cis_op_e;

  typedef enum logic [2:0] {
    TRAP_NONE, TRAP_ILLEGAL, TRAP_OVF, TRAP_BREAK, TRAP_SWI
  } cis_trap_e;

  typedef enum logic [2:0] {
    EXT_NONE, EXT_WDT, EXT_OSC, EXT_VMON1, EXT_PERIPH
  } cis_ext_e;
endpackage

// ### core/cis_am_if.sv
// Purpose: carrier between the top and the address match comparator
// Assumes: one fetch address per cycle
// Notes: hit is registered inside the comparator
`timescale 1ns/100ps
interface cis_am_if;
  logic fetch_valid;
  logic [cis_pkg::PC_W-1:0] fetch_pc;
  logic [cis_pkg::AM_CH-1:0] en;
  logic [cis_pkg::AM_CH-1:0][cis_pkg::PC_W-1:0] target;
  logic hit;
  logic chan;
  modport cmp (input fetch_valid, fetch_pc, en, target, output hit, chan);
  modport top (output fetch_valid, fetch_pc, en, target, input hit, chan);
endinterface

// ### core/cis_addr_match.sv
// Purpose: compares the next instruction address with the match targets
// Assumes: fetch_pc names the instruction about to execute
// Notes: channel 0 wins when both channels match the same address
`timescale 1ns/100ps
module cis_addr_match (
  input wire logic clk_sys,
  input wire logic arst_n,
  cis_am_if.cmp am
);
  typedef struct packed {
    logic hit;
    logic chan;
  } cis_am_s;

  cis_am_s st_r;
  cis_am_s st_nxt;
  logic [cis_pkg::AM_CH-1:0] match;

  genvar g;
  generate
    for (g = 0; g < cis_pkg::AM_CH; g++) begin : g_ch
      assign match[g] = am.en[g] && (am.fetch_pc == am.target[g]);
    end
  endgenerate

  always_comb begin
    st_nxt = '0;
    st_nxt.hit = am.fetch_valid && (|match);
    st_nxt.chan = !match[0];
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign am.hit = st_r.hit;
  assign am.chan = st_r.chan;

  a_am_hit_raise: assert property (@(posedge clk_sys) disable iff (!arst_n)
    am.fetch_valid && am.en[0] && am.fetch_pc == am.target[0]
    |=> am.hit && !am.chan) else $error("address match 0 missed");
  a_am_hit_cause: assert property (@(posedge clk_sys) disable iff (!arst_n)
    am.hit |-> $past(am.fetch_valid) && ($past(am.en) != 2'h0))
    else $error("address match without enabled channel");
  c_am_ch1: cover property (@(posedge clk_sys) disable iff (!arst_n) am.hit && am.chan);
endmodule

// ### core/cis_src.sv
// Purpose: raises trap, address match and forwarded interrupt requests
// Assumes: the core stalls the next instruction while a trap request is out
// Notes: priority among forwarded sources is fixed here; the vector layout lives in the core
`timescale 1ns/100ps
module cis_src (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic exec_valid,
  input wire cis_pkg::cis_op_e exec_op,
  input wire logic exec_ovf,
  input wire logic [cis_pkg::NUM_W-1:0] exec_num,
  input wire logic exec_saved_ssel,
  input wire logic fetch_valid,
  input wire logic [cis_pkg::PC_W-1:0] fetch_pc,
  input wire logic [cis_pkg::AM_CH-1:0] addr_match_en,
  input wire logic [cis_pkg::PC_W-1:0] addr_match_target0,
  input wire logic [cis_pkg::PC_W-1:0] addr_match_target1,
  input wire logic wdt_req,
  input wire logic osc_stop_req,
  input wire logic vmon1_req,
  input wire logic [cis_pkg::PER_N-1:0] periph_req,
  output logic trap_req_r,
  output cis_pkg::cis_trap_e trap_kind_r,
  output logic [cis_pkg::VEC_W-1:0] trap_vec_r,
  output logic ovf_flag_r,
  output logic stack_sel_r,
  output logic ssel_push_r,
  output logic ssel_push_val_r,
  output logic am_req_r,
  output logic am_chan_r,
  output logic ext_req_r,
  output cis_pkg::cis_ext_e ext_kind_r,
  output logic [cis_pkg::VEC_W-1:0] ext_vec_r
);
  typedef struct packed {
    logic trap_req;
    cis_pkg::cis_trap_e trap_kind;
    logic [cis_pkg::VEC_W-1:0] trap_vec;
    logic ovf;
    logic ssel;
    logic push;
    logic push_val;
    logic am_req;
    logic am_chan;
    logic ext_req;
    cis_pkg::cis_ext_e ext_kind;
    logic [cis_pkg::VEC_W-1:0] ext_vec;
  } cis_state_s;

  cis_state_s st_r;
  cis_state_s st_nxt;
  cis_am_if am ();

  assign am.fetch_valid = fetch_valid;
  assign am.fetch_pc = fetch_pc;
  assign am.en = addr_match_en;
  // one driver for the whole target array keeps the interface variable single-sourced
  assign am.target = {addr_match_target1, addr_match_target0};

  cis_addr_match u_am (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .am(am)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.trap_req = 1'h0;
    st_nxt.trap_kind = cis_pkg::TRAP_NONE;
    st_nxt.trap_vec = '0;
    st_nxt.push = 1'h0;
    st_nxt.push_val = 1'h0;
    st_nxt.am_req = am.hit;
    st_nxt.am_chan = am.chan;
    if (exec_valid) begin
      case (exec_op)
        cis_pkg::OP_ARITH: begin
          st_nxt.ovf = exec_ovf;
        end
        cis_pkg::OP_ILLEGAL: begin
          st_nxt.trap_req = 1'h1;
          st_nxt.trap_kind = cis_pkg::TRAP_ILLEGAL;
        end
        cis_pkg::OP_OVF_TRAP: begin
          st_nxt.trap_req = st_r.ovf;
          st_nxt.trap_kind = st_r.ovf ? cis_pkg::TRAP_OVF : cis_pkg::TRAP_NONE;
        end
        cis_pkg::OP_BREAK: begin
          st_nxt.trap_req = 1'h1;
          st_nxt.trap_kind = cis_pkg::TRAP_BREAK;
        end
        cis_pkg::OP_SWI: begin
          // out of range numbers are dropped so no stray vector is ever fetched
          if (exec_num <= cis_pkg::SWI_MAX) begin
            st_nxt.trap_req = 1'h1;
            st_nxt.trap_kind = cis_pkg::TRAP_SWI;
            st_nxt.trap_vec = exec_num[cis_pkg::VEC_W-1:0];
            if (exec_num <= cis_pkg::SWI_LOW_MAX) begin
              st_nxt.push = 1'h1;
              st_nxt.push_val = st_r.ssel;
              st_nxt.ssel = cis_pkg::SSEL_IRQ;
            end
          end
        end
        cis_pkg::OP_RET_SWI: begin
          st_nxt.ssel = exec_saved_ssel;
        end
        default: begin
        end
      endcase
    end
    // forwarded sources: fixed priority, lowest peripheral number first
    st_nxt.ext_req = 1'h1;
    st_nxt.ext_vec = '0;
    if (wdt_req) begin
      st_nxt.ext_kind = cis_pkg::EXT_WDT;
    end else if (osc_stop_req) begin
      st_nxt.ext_kind = cis_pkg::EXT_OSC;
    end else if (vmon1_req) begin
      st_nxt.ext_kind = cis_pkg::EXT_VMON1;
    end else if (|periph_req) begin
      st_nxt.ext_kind = cis_pkg::EXT_PERIPH;
      for (int i = cis_pkg::PER_N - 1; i >= 0; i--) begin
        if (periph_req[i]) begin
          st_nxt.ext_vec = i[cis_pkg::VEC_W-1:0];
        end
      end
    end else begin
      st_nxt.ext_req = 1'h0;
      st_nxt.ext_kind = cis_pkg::EXT_NONE;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.ovf <= cis_pkg::OVF_RST;
      st_r.ssel <= cis_pkg::SSEL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign trap_req_r = st_r.trap_req;
  assign trap_kind_r = st_r.trap_kind;
  assign trap_vec_r = st_r.trap_vec;
  assign ovf_flag_r = st_r.ovf;
  assign stack_sel_r = st_r.ssel;
  assign ssel_push_r = st_r.push;
  assign ssel_push_val_r = st_r.push_val;
  assign am_req_r = st_r.am_req;
  assign am_chan_r = st_r.am_chan;
  assign ext_req_r = st_r.ext_req;
  assign ext_kind_r = st_r.ext_kind;
  assign ext_vec_r = st_r.ext_vec;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_illegal_trap: assert property (exec_valid && exec_op == cis_pkg::OP_ILLEGAL
    |=> trap_req_r && trap_kind_r == cis_pkg::TRAP_ILLEGAL)
    else $error("illegal opcode did not trap");
  a_ovf_trap_set: assert property (exec_valid && exec_op == cis_pkg::OP_OVF_TRAP
    |=> trap_req_r == $past(ovf_flag_r))
    else $error("overflow trap does not follow wrap flag");
  a_ovf_flag_upd: assert property (exec_valid && exec_op == cis_pkg::OP_ARITH
    |=> ovf_flag_r == $past(exec_ovf))
    else $error("wrap flag not updated");
  a_break_trap: assert property (exec_valid && exec_op == cis_pkg::OP_BREAK
    |=> trap_req_r && trap_kind_r == cis_pkg::TRAP_BREAK)
    else $error("break opcode did not trap");
  a_swi_range: assert property (exec_valid && exec_op == cis_pkg::OP_SWI
    && exec_num > cis_pkg::SWI_MAX |=> !trap_req_r)
    else $error("out of range software interrupt raised");
  a_swi_vector: assert property (exec_valid && exec_op == cis_pkg::OP_SWI
    && exec_num <= cis_pkg::SWI_MAX
    |=> trap_req_r && trap_vec_r == $past(exec_num[5:0]))
    else $error("software interrupt vector mismatch");
  a_swi_low_ssel: assert property (exec_valid && exec_op == cis_pkg::OP_SWI
    && exec_num <= cis_pkg::SWI_LOW_MAX
    |=> ssel_push_r && ssel_push_val_r == $past(stack_sel_r) && !stack_sel_r)
    else $error("stack select not saved and cleared");
  a_ret_restore: assert property (exec_valid && exec_op == cis_pkg::OP_RET_SWI
    |=> stack_sel_r == $past(exec_saved_ssel))
    else $error("stack select not restored");
  a_swi_high_keep: assert property (exec_valid && exec_op == cis_pkg::OP_SWI
    && exec_num > cis_pkg::SWI_LOW_MAX |=> $stable(stack_sel_r) && !ssel_push_r)
    else $error("stack select touched by high number");
  a_am_forward: assert property (am.hit |=> am_req_r)
    else $error("address match not forwarded");
  a_wdt_first: assert property (wdt_req |=> ext_req_r && ext_kind_r == cis_pkg::EXT_WDT)
    else $error("watchdog request not forwarded");
  a_osc_fwd: assert property (osc_stop_req && !wdt_req
    |=> ext_req_r && ext_kind_r == cis_pkg::EXT_OSC)
    else $error("oscillation stop not forwarded");
  a_vmon_fwd: assert property (vmon1_req && !wdt_req && !osc_stop_req
    |=> ext_kind_r == cis_pkg::EXT_VMON1)
    else $error("voltage monitor not forwarded");
  a_periph_vec: assert property (ext_kind_r == cis_pkg::EXT_PERIPH
    |-> |($past(periph_req) & (64'h1 << ext_vec_r)))
    else $error("peripheral vector without request");
  a_trap_once: assert property (trap_req_r |-> $past(exec_valid))
    else $error("trap without an executing instruction");
  c_swi_low: cover property (trap_req_r && ssel_push_r);
  c_ovf_trap: cover property (trap_req_r && trap_kind_r == cis_pkg::TRAP_OVF);
  c_periph: cover property (ext_req_r && ext_kind_r == cis_pkg::EXT_PERIPH);
endmodule

// ### testbench/cis_core_model.sv
// Purpose: stand-in for the execute unit, presents one instruction per call
// Assumes: the design samples exec_* on the rising edge of clk_sys
// Notes: an idle cycle precedes every instruction, so valid never toggles twice in a step
`timescale 1ns/100ps
module cis_core_model (
  input wire logic clk_sys,
  output logic exec_valid,
  output cis_pkg::cis_op_e exec_op,
  output logic exec_ovf,
  output logic [cis_pkg::NUM_W-1:0] exec_num,
  output logic exec_saved_ssel
);
  initial begin
    exec_valid = 1'h0;
    exec_op = cis_pkg::OP_OTHER;
    exec_ovf = 1'h0;
    exec_num = 8'h00;
    exec_saved_ssel = 1'h0;
  end

  // only documented classes are issued, never a single step request
  task automatic issue(input cis_pkg::cis_op_e op, input logic ovf,
                       input logic [cis_pkg::NUM_W-1:0] num, input logic ssel);
    @(posedge clk_sys);
    #1;
    exec_valid = 1'h1;
    exec_op = op;
    exec_ovf = ovf;
    exec_num = num;
    exec_saved_ssel = ssel;
    @(posedge clk_sys);
    #1;
    // qualifiers invert once released so stale values never look valid
    exec_valid = 1'h0;
    exec_ovf = ~ovf;
    exec_num = ~num;
    exec_saved_ssel = ~ssel;
  endtask
endmodule

// ### testbench/tb.sv
// Purpose: self-checking bench of the interrupt source logic
// Assumes: registered outputs answer one edge after the request
// Notes: address match answers two edges after the fetch
`timescale 1ns/100ps
module tb;
  logic clk_sys, arst_n, fetch_valid, wdt_req, osc_stop_req, vmon1_req;
  logic exec_valid, exec_ovf, exec_saved_ssel;
  cis_pkg::cis_op_e exec_op;
  logic [cis_pkg::NUM_W-1:0] exec_num;
  logic [cis_pkg::PC_W-1:0] fetch_pc, addr_match_target0, addr_match_target1;
  logic [cis_pkg::AM_CH-1:0] addr_match_en;
  logic [cis_pkg::PER_N-1:0] periph_req;
  logic trap_req_r, ovf_flag_r, stack_sel_r, ssel_push_r, ssel_push_val_r;
  logic am_req_r, am_chan_r, ext_req_r;
  cis_pkg::cis_trap_e trap_kind_r;
  cis_pkg::cis_ext_e ext_kind_r;
  logic [cis_pkg::VEC_W-1:0] trap_vec_r, ext_vec_r;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  cis_core_model i_cis_core_model (.clk_sys(clk_sys), .exec_valid(exec_valid),
    .exec_op(exec_op), .exec_ovf(exec_ovf), .exec_num(exec_num),
    .exec_saved_ssel(exec_saved_ssel));

  cis_src i_cis_src (.clk_sys(clk_sys), .arst_n(arst_n), .exec_valid(exec_valid),
    .exec_op(exec_op), .exec_ovf(exec_ovf), .exec_num(exec_num),
    .exec_saved_ssel(exec_saved_ssel), .fetch_valid(fetch_valid), .fetch_pc(fetch_pc),
    .addr_match_en(addr_match_en), .addr_match_target0(addr_match_target0),
    .addr_match_target1(addr_match_target1), .wdt_req(wdt_req),
    .osc_stop_req(osc_stop_req), .vmon1_req(vmon1_req), .periph_req(periph_req),
    .trap_req_r(trap_req_r), .trap_kind_r(trap_kind_r), .trap_vec_r(trap_vec_r),
    .ovf_flag_r(ovf_flag_r), .stack_sel_r(stack_sel_r), .ssel_push_r(ssel_push_r),
    .ssel_push_val_r(ssel_push_val_r), .am_req_r(am_req_r), .am_chan_r(am_chan_r),
    .ext_req_r(ext_req_r), .ext_kind_r(ext_kind_r), .ext_vec_r(ext_vec_r));

  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // a hang shows up well before this ceiling
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic t_plain_traps();
    i_cis_core_model.issue(cis_pkg::OP_ILLEGAL, 1'h0, 8'h00, 1'h0);
    chk("illegal trap", cis_pkg::TRAP_ILLEGAL, trap_kind_r);
    tick();
    chk("trap pulse end", 1'h0, trap_req_r);
    repeat (2) begin
      i_cis_core_model.issue(cis_pkg::OP_BREAK, 1'h0, 8'h00, 1'h0);
      chk("break trap", cis_pkg::TRAP_BREAK, trap_kind_r);
    end
  endtask

  task automatic t_overflow();
    i_cis_core_model.issue(cis_pkg::OP_ARITH, 1'h1, 8'h00, 1'h0);
    chk("wrap flag set", 1'h1, ovf_flag_r);
    i_cis_core_model.issue(cis_pkg::OP_OVF_TRAP, 1'h0, 8'h00, 1'h0);
    chk("overflow trap", cis_pkg::TRAP_OVF, trap_kind_r);
    i_cis_core_model.issue(cis_pkg::OP_ARITH, 1'h0, 8'h00, 1'h0);
    chk("wrap flag clear", 1'h0, ovf_flag_r);
    i_cis_core_model.issue(cis_pkg::OP_OVF_TRAP, 1'h0, 8'h00, 1'h0);
    chk("no overflow trap", 1'h0, trap_req_r);
  endtask

  task automatic t_swi();
    logic [7:0] nums[5] = '{8'h05, 8'h1F, 8'h20, 8'h3F, 8'h40};
    foreach (nums[i]) begin
      i_cis_core_model.issue(cis_pkg::OP_RET_SWI, 1'h0, 8'h00, 1'h1);
      chk("stack select restore", 1'h1, stack_sel_r);
      i_cis_core_model.issue(cis_pkg::OP_SWI, 1'h0, nums[i], 1'h0);
      chk("swi request", nums[i] <= 8'h3F, trap_req_r);
      chk("swi vector", (nums[i] <= 8'h3F) ? nums[i][5:0] : 6'h00, trap_vec_r);
      chk("stack push", nums[i] <= 8'h1F, ssel_push_r);
      chk("pushed value", nums[i] <= 8'h1F, ssel_push_val_r);
      chk("stack select", nums[i] > 8'h1F, stack_sel_r);
    end
  endtask

  task automatic t_addr_match();
    addr_match_target0 = 20'h01234;
    addr_match_target1 = 20'h0ABCD;
    // pass 0: disabled channel, pass 1: channel 1, pass 2: both enabled, only channel 0 matches
    for (int k = 0; k < 3; k++) begin
      addr_match_en = (k == 2) ? 2'h3 : 2'h2;
      fetch_valid = 1'h1;
      fetch_pc = (k == 1) ? 20'h0ABCD : 20'h01234;
      tick();
      fetch_valid = 1'h0;
      fetch_pc = ~fetch_pc;
      tick();
      chk("match request", k != 0, am_req_r);
      if (k != 0) begin
        chk("match channel", k == 1, am_chan_r);
      end
    end
    tick();
    chk("match pulse end", 1'h0, am_req_r);
  endtask

  task automatic t_forward();
    wdt_req = 1'h1;
    vmon1_req = 1'h1;
    tick();
    chk("watchdog source", cis_pkg::EXT_WDT, ext_kind_r);
    wdt_req = 1'h0;
    osc_stop_req = 1'h1;
    tick();
    chk("osc stop source", cis_pkg::EXT_OSC, ext_kind_r);
    osc_stop_req = 1'h0;
    tick();
    chk("voltage source", cis_pkg::EXT_VMON1, ext_kind_r);
    vmon1_req = 1'h0;
    periph_req = 64'h0000_0100_0000_0200;
    tick();
    chk("peripheral vector", 6'h09, ext_vec_r);
    periph_req = '0;
    tick();
    chk("no request", 1'h0, ext_req_r);
  endtask

  // reset in mid-run must drop flags and requests at once, without a clock edge
  task automatic t_reset();
    i_cis_core_model.issue(cis_pkg::OP_RET_SWI, 1'h0, 8'h00, 1'h1);
    i_cis_core_model.issue(cis_pkg::OP_ARITH, 1'h1, 8'h00, 1'h0);
    wdt_req = 1'h1;
    tick();
    arst_n = 1'h0;
    #1;
    chk("reset wrap flag", cis_pkg::OVF_RST, ovf_flag_r);
    chk("reset stack select", cis_pkg::SSEL_RST, stack_sel_r);
    chk("reset forward", 1'h0, ext_req_r);
    wdt_req = 1'h0;
    tick();
    arst_n = 1'h1;
    tick();
    chk("wrap flag after reset", cis_pkg::OVF_RST, ovf_flag_r);
    chk("forward after reset", 1'h0, ext_req_r);
  endtask

  initial begin
    arst_n = 1'h0;
    fetch_valid = 1'h0;
    fetch_pc = '0;
    addr_match_en = 2'h0;
    addr_match_target0 = '0;
    addr_match_target1 = '0;
    wdt_req = 1'h0;
    osc_stop_req = 1'h0;
    vmon1_req = 1'h0;
    periph_req = '0;
    repeat (4) @(posedge clk_sys);
    #1;
    arst_n = 1'h1;
    t_plain_traps();
    t_overflow();
    t_swi();
    t_addr_match();
    t_forward();
    t_reset();
    complete_run();
  end
endmodule
